//--- include/cbc_consts.svh
// Constants for the local bus cycle and burst control block
`ifndef CBC_CONSTS_SVH
`define CBC_CONSTS_SVH
`define CBC_AW          32
`define CBC_DW          32
`define CBC_DEFW        4
`define CBC_LENW        3
`define CBC_LEN_ONE     3'h1
`define CBC_LEN_MAX     3'h4
`define CBC_FIFO_DEPTH  16
`define CBC_LVLW        5
`define CBC_FIFO_ROOM   5'hc
`endif

//--- include/cbc_pkg.sv
// Types for the local bus cycle and burst control block
package cbc_pkg;
    typedef enum logic [1:0] {
        CBC_IDLE,
        CBC_T1,
        CBC_T2,
        CBC_HOLD
    } cbc_state_type;
endpackage : cbc_pkg

//--- src/cbc_sync.sv
// Three flop synchroniser with agreement filter
`include "cbc_consts.svh"
module cbc_sync (
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    input  wire logic i_async,
    output logic      o_sync
);
    typedef struct packed {
        logic f1;
        logic f2;
        logic f3;
        logic out;
    } cbc_sync_state_type;

    cbc_sync_state_type s_r;
    cbc_sync_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.f1 = i_async;
        s_nxt.f2 = s_r.f1;
        s_nxt.f3 = s_r.f2;
        // Only count a change once the last two stages agree
        if (s_r.f2 == s_r.f3) begin
            s_nxt.out = s_r.f3;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_sync = s_r.out;
endmodule : cbc_sync

//--- src/cbc_fifo.sv
// Read data FIFO with valid and ready on both sides
`include "cbc_consts.svh"
module cbc_fifo #(
    parameter int WIDTH = `CBC_DW,
    parameter int DEPTH = `CBC_FIFO_DEPTH
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_reset_n,
    input  wire logic                     i_in_valid,
    output logic                          o_in_ready,
    input  wire logic [WIDTH-1:0]         i_in_data,
    output logic                          o_out_valid,
    input  wire logic                     i_out_ready,
    output logic [WIDTH-1:0]              o_out_data,
    output logic [$clog2(DEPTH+1)-1:0]    o_level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [LW-1:0]               cnt;
    } cbc_fifo_state_type;

    cbc_fifo_state_type s_r;
    cbc_fifo_state_type s_nxt;
    logic               push;
    logic               pop;

    assign o_in_ready  = (s_r.cnt != LW'(DEPTH));
    assign o_out_valid = (s_r.cnt != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = i_in_data;
            s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + AW'(1);
        end
        if (pop) begin
            s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + AW'(1);
        end
        s_nxt.cnt = s_r.cnt + LW'(push) - LW'(pop);
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_out_data = s_r.mem[s_r.rp];
    assign o_level    = s_r.cnt;
endmodule : cbc_fifo

//--- src/cbc_bus_ctrl.sv
// Local bus cycle and burst control, processor side
//
// Summary of operation
// R1 - The address strobe marks a valid cycle definition and address on the bus.
// R2 - The strobe goes low in the very clock in which the definition and address are first driven.
// R3 - The strobe is active low and stops being driven while the bus is floated for hold.
// R4 - External logic ends the cycle with the plain ready: read data valid or write data taken.
// R5 - The plain ready is ignored while idle and at the end of the first clock of a cycle.
// R6 - In burst cycles the burst ready carries the same completion meaning as the plain ready.
// R7 - The burst ready is ignored while idle and at the end of the first clock of a cycle.
// R8 - The burst ready is sampled in the second and every later clock of a cycle.
// R9 - Read data is captured in every clock in which the burst ready is sampled active.
// R10 - With both readies active together, the plain ready wins and the burst ends early.
// R11 - The burst ready is active low, and an undriven pin reads as inactive.
// R12 - The final transfer output is asserted so that the next burst ready ends the cycle.
// R13 - The final transfer output is produced for non-burst cycles as well as bursts.
// R14 - The final transfer output is active low and undriven while another master holds the bus.
// R15 - Address and cycle definition stay stable from the strobe until a ready ends the cycle.
`include "cbc_consts.svh"
module cbc_bus_ctrl (
    input  wire logic                   i_clock,
    input  wire logic                   i_reset_n,
    // Request side
    input  wire logic                   i_req_valid,
    output logic                        o_req_ready,
    input  wire logic [`CBC_AW-1:0]     i_req_addr,
    input  wire logic [`CBC_DEFW-1:0]   i_req_def,
    input  wire logic                   i_req_write,
    input  wire logic [`CBC_LENW-1:0]   i_req_len,
    input  wire logic [`CBC_DW-1:0]     i_req_wdata,
    output logic                        o_cycle_done,
    output logic                        o_cycle_aborted,
    // Read data side
    output logic                        o_rd_valid,
    input  wire logic                   i_rd_ready,
    output logic [`CBC_DW-1:0]          o_rd_data,
    // Bus pins
    output logic [`CBC_AW-1:0]          o_addr,
    output logic [`CBC_DEFW-1:0]        o_cycle_def,
    output logic                        o_addr_oe,
    output logic                        o_addr_strobe_n,
    output logic                        o_addr_strobe_oe,
    output logic                        o_final_transfer_n,
    output logic                        o_final_transfer_oe,
    output logic [`CBC_DW-1:0]          o_data,
    output logic                        o_data_oe,
    input  wire logic [`CBC_DW-1:0]     i_data,
    input  wire logic                   i_ready_n,
    input  wire logic                   i_burst_xfer_ready_n,
    input  wire logic                   i_hold_req,
    output logic                        o_hold_ack
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        cbc_pkg::cbc_state_type st;
        logic [`CBC_AW-1:0]     addr;
        logic [`CBC_DEFW-1:0]   def;
        logic                   write;
        logic [`CBC_DW-1:0]     wdata;
        logic [`CBC_LENW-1:0]   remain;
        logic                   astb;
        logic                   final_xfer;
        logic                   drive;
        logic                   hold_ack;
        logic                   done;
        logic                   aborted;
    } cbc_state_struct_type;

    cbc_state_struct_type s_r;
    cbc_state_struct_type s_nxt;

    logic                   hold_sync;
    logic                   fifo_in_ready;
    logic [`CBC_LVLW-1:0]   fifo_level;
    logic                   capture;
    logic                   start;
    logic                   rdy;
    logic                   burst_xfer_ready_n;

    // Zero length means one transfer; writes are always single
    function automatic logic [`CBC_LENW-1:0] clamp_len(input logic [`CBC_LENW-1:0] len,
                                                       input logic wr);
        if (wr || len == '0) begin
            return `CBC_LEN_ONE;
        end
        return (len > `CBC_LEN_MAX) ? `CBC_LEN_MAX : len;
    endfunction : clamp_len

    // ****************************************
    // Hold request synchroniser
    // ****************************************
    cbc_sync u_hold_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   (i_hold_req),
        .o_sync    (hold_sync)
    );

    // ****************************************
    // Read data FIFO
    // ****************************************
    // Sixteen words hold four full bursts while the reader stalls
    cbc_fifo #(
        .WIDTH (`CBC_DW),
        .DEPTH (`CBC_FIFO_DEPTH)
    ) u_rd_fifo (
        .i_clock     (i_clock),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (capture),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (i_data),
        .o_out_valid (o_rd_valid),
        .i_out_ready (i_rd_ready),
        .o_out_data  (o_rd_data),
        .o_level     (fifo_level)
    );

    // ****************************************
    // Cycle control
    // ****************************************
    // A read only starts with room for a whole burst, so a stalled reader
    // holds back new read cycles instead of dropping captured data.
    assign o_req_ready = (s_r.st == cbc_pkg::CBC_IDLE) && !hold_sync
                         && (i_req_write || (fifo_level <= `CBC_FIFO_ROOM));
    assign start = i_req_valid && o_req_ready;

    // Same-clock inputs: the far side meets setup, so no synchroniser
    // Readies only count from the second clock on; pins are active low
    assign rdy     = (s_r.st == cbc_pkg::CBC_T2) && !i_ready_n;                          // R5 R4
    assign burst_xfer_ready_n    = (s_r.st == cbc_pkg::CBC_T2) && !i_burst_xfer_ready_n;               // R7 R8 R11
    assign capture = (rdy || burst_xfer_ready_n) && !s_r.write;                                       // R9 R6

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.aborted = 1'b0;
        case (s_r.st)
            cbc_pkg::CBC_IDLE: begin
                // Hold only while idle, so a running cycle always finishes
                if (hold_sync) begin
                    s_nxt.st = cbc_pkg::CBC_HOLD;
                    s_nxt.drive = 1'b0;                                                 // R3 R14
                    s_nxt.hold_ack = 1'b1;
                end else if (start) begin
                    s_nxt.st = cbc_pkg::CBC_T1;
                    s_nxt.addr = i_req_addr;                                            // R2
                    s_nxt.def = i_req_def;
                    s_nxt.write = i_req_write;
                    s_nxt.wdata = i_req_wdata;
                    s_nxt.remain = clamp_len(i_req_len, i_req_write);
                    s_nxt.astb = 1'b1;                                                  // R1 R2
                    s_nxt.final_xfer = (clamp_len(i_req_len, i_req_write) == `CBC_LEN_ONE); // R13
                end
            end
            cbc_pkg::CBC_T1: begin
                s_nxt.astb = 1'b0;
                s_nxt.st = cbc_pkg::CBC_T2;
            end
            cbc_pkg::CBC_T2: begin
                if (rdy) begin
                    // Plain ready wins and ends the burst at once
                    s_nxt.st = cbc_pkg::CBC_IDLE;                                       // R10 R4
                    s_nxt.done = 1'b1;
                    s_nxt.aborted = (s_r.remain != `CBC_LEN_ONE);
                    s_nxt.final_xfer = 1'b0;
                end else if (burst_xfer_ready_n) begin
                    if (s_r.remain == `CBC_LEN_ONE) begin
                        s_nxt.st = cbc_pkg::CBC_IDLE;                                   // R12
                        s_nxt.done = 1'b1;
                        s_nxt.final_xfer = 1'b0;
                    end else begin
                        s_nxt.remain = s_r.remain - `CBC_LEN_ONE;
                        s_nxt.final_xfer = (s_r.remain - `CBC_LEN_ONE == `CBC_LEN_ONE); // R12
                    end
                end
            end
            cbc_pkg::CBC_HOLD: begin
                if (!hold_sync) begin
                    s_nxt.st = cbc_pkg::CBC_IDLE;
                    s_nxt.drive = 1'b1;
                    s_nxt.hold_ack = 1'b0;
                end
            end
            default: begin
                s_nxt.st = cbc_pkg::CBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            s_r <= '0;
            s_r.drive <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Address held in flops for the whole cycle
    // No stepping within a burst; the far side counts the beats
    assign o_addr              = s_r.addr;                                              // R15
    assign o_cycle_def         = s_r.def;
    assign o_addr_oe           = s_r.drive;
    assign o_addr_strobe_n     = !s_r.astb;                                             // R3
    assign o_addr_strobe_oe    = s_r.drive;                                             // R3
    assign o_final_transfer_n  = !s_r.final_xfer;                                       // R14
    assign o_final_transfer_oe = s_r.drive;                                             // R14
    assign o_data              = s_r.wdata;
    assign o_data_oe           = s_r.drive && s_r.write && (s_r.st != cbc_pkg::CBC_IDLE);
    assign o_hold_ack          = s_r.hold_ack;
    assign o_cycle_done        = s_r.done;
    assign o_cycle_aborted     = s_r.aborted;

    // ****************************************
    // Checks
    // ****************************************
    logic busy;
    assign busy = (s_r.st == cbc_pkg::CBC_T1) || (s_r.st == cbc_pkg::CBC_T2);

    chk_strobe_one_clock: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R1
        $fell(o_addr_strobe_n) |=> o_addr_strobe_n)
        else $error("Address strobe not a single clock");

    chk_strobe_with_addr: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R2
        start |=> !o_addr_strobe_n && o_addr == $past(i_req_addr) && o_addr_oe)
        else $error("Strobe not in first address clock");

    chk_strobe_float_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R3
        o_hold_ack |-> !o_addr_strobe_oe && !o_addr_oe)
        else $error("Strobe driven during hold");

    chk_ready_first_clock: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R5
        !o_addr_strobe_n && !i_ready_n |=> !o_cycle_done)
        else $error("Plain ready taken in first clock");

    chk_burst_first_clock: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R7
        (!o_addr_strobe_n || !busy) |-> !capture)
        else $error("Burst ready taken when ignored");

    chk_burst_capture: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R9
        busy && o_addr_strobe_n && !s_r.write && !i_burst_xfer_ready_n |-> capture)
        else $error("Data not captured on burst ready");

    chk_both_ready_abort: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R10
        busy && o_addr_strobe_n && !i_ready_n && !i_burst_xfer_ready_n && o_final_transfer_n
        |=> o_cycle_done && o_cycle_aborted ##1 !o_cycle_done)
        else $error("Both readies did not abort burst");

    chk_final_ends_cycle: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R12
        busy && o_addr_strobe_n && !o_final_transfer_n && !i_burst_xfer_ready_n
        |=> o_cycle_done && !o_cycle_aborted && o_final_transfer_n)
        else $error("Final transfer did not end cycle");

    chk_final_single: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R13
        start && clamp_len(i_req_len, i_req_write) == `CBC_LEN_ONE |=> !o_final_transfer_n [*2])
        else $error("Final transfer missing in single cycle");

    chk_final_float_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R14
        o_hold_ack |-> !o_final_transfer_oe)
        else $error("Final transfer driven during hold");

    chk_addr_stable: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R15
        busy && $past(busy) |-> $stable(o_addr) && $stable(o_cycle_def))
        else $error("Address changed inside a cycle");

    // ****************************************
    // Handshake checks
    // ****************************************
    // All but chk_done_one_clock, chk_capture_has_room and chk_hold_when_idle watch the ready pins directly so a wrong state decode cannot mask them
    chk_ready_ends_cycle: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R4
        busy && o_addr_strobe_n && !i_ready_n |=> o_cycle_done)
        else $error("Plain ready did not end the cycle");

    chk_done_one_clock: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R4
        o_cycle_done |=> !o_cycle_done)
        else $error("Cycle done longer than one clock");

    chk_idle_ready_ignored: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R5
        !busy && !i_ready_n |=> !o_cycle_done)
        else $error("Plain ready taken while idle");

    chk_burst_ends_write: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R6
        busy && o_addr_strobe_n && s_r.write && !i_burst_xfer_ready_n |=> o_cycle_done && !o_data_oe)
        else $error("Burst ready did not accept write data");

    chk_burst_keeps_going: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R8
        busy && o_addr_strobe_n && i_ready_n && !i_burst_xfer_ready_n && o_final_transfer_n
        |=> busy && o_addr_strobe_n && !o_cycle_done)
        else $error("Burst stopped sampling before its last transfer");

    chk_high_ready_idle: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R11
        busy && i_ready_n && i_burst_xfer_ready_n |-> !capture ##1 !o_cycle_done)
        else $error("High ready levels ended a cycle");

    chk_capture_has_room: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R9
        capture |-> fifo_in_ready)
        else $error("Captured word found the buffer full");

    chk_hold_when_idle: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R3
        o_hold_ack |-> !busy && !o_data_oe)
        else $error("Hold granted inside a cycle");
endmodule : cbc_bus_ctrl

//--- tb/cbc_mem_model.sv
// Far side model: memory and bus controller answering local bus cycles
module cbc_mem_model (
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic        i_strobe_n,
    input  wire logic        i_final_n,
    input  wire logic [31:0] i_addr,
    input  wire logic [1:0]  i_mode,
    input  wire logic [1:0]  i_waits,
    input  wire logic [1:0]  i_abort_at,
    input  wire logic        i_idle_low,
    output logic             o_ready_n,
    output logic             o_burst_ready_n,
    output logic [31:0]      o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************
    // Cycle tracking and ready generation
    // ************************************************
    // Mode 0 burst ready, 1 plain ready, 2 both together at abort_at
    logic        act = 1'b0;
    logic [1:0]  wc;
    logic [2:0]  idx;
    logic [31:0] base;
    logic        rn;
    logic        bn;
    initial begin
        o_ready_n = 1'b1;
        o_burst_ready_n = 1'b1;
        o_data = 32'h0;
    end
    always @(posedge i_clock) begin
        if (!i_reset_n) act = 1'b0;
        else if (!i_strobe_n) begin
            act = 1'b1;
            idx = 3'h0;
            wc = i_waits;
            base = i_addr;
        end else if (act && !(o_ready_n && o_burst_ready_n)) begin
            if (!o_ready_n || !i_final_n) act = 1'b0;
            else begin
                idx = idx + 3'h1;
                wc = i_waits;
            end
        end else if (act && wc != 2'h0) wc = wc - 2'h1;
        // Idle plain ready sits at the pull-up level unless told to stress; idle burst ready always stays high
        rn = act ? 1'b1 : ~i_idle_low;
        bn = 1'b1;
        if (act && wc == 2'h0) begin
            rn = !(i_mode == 2'h1 || (i_mode == 2'h2 && idx[1:0] == i_abort_at));
            bn = (i_mode == 2'h1);
            o_data <= base + 32'(idx);
        end else o_data <= ~o_data;
        o_ready_n <= rn;
        o_burst_ready_n <= bn;
    end
endmodule : cbc_mem_model

//--- tb/cbc_bus_ctrl_tb.sv
// Self-checking bench for the local bus cycle and burst control block
module cbc_bus_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clock, i_reset_n, i_req_valid, i_req_write, i_rd_ready, i_hold_req;
    logic [31:0] i_req_addr, i_req_wdata, o_addr, o_rd_data, exp_addr, mdata, wd_q, exp_wd;
    logic [31:0] seed = 32'h4e79;
    logic [3:0]  i_req_def, def_q, exp_def;
    logic [2:0]  i_req_len;
    logic [1:0]  mode, abort_at, waits;
    logic        idle_low, stall, exp_fin, rdy_n, burst_xfer_ready_n_n, doe, exp_wr;
    logic        o_req_ready, o_cycle_done, o_cycle_aborted, o_rd_valid, o_addr_oe, o_hold_ack;
    logic        o_addr_strobe_n, o_addr_strobe_oe, o_final_transfer_n, o_final_transfer_oe;
    logic [31:0] exp_rd[$];
    logic        exp_ab[$];
    int          error_cnt = 0;
    int          num_checks = 0;
    int          t;

    cbc_bus_ctrl dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
        .o_req_ready(o_req_ready), .i_req_addr(i_req_addr), .i_req_def(i_req_def),
        .i_req_write(i_req_write), .i_req_len(i_req_len), .i_req_wdata(i_req_wdata),
        .o_cycle_done(o_cycle_done), .o_cycle_aborted(o_cycle_aborted), .o_rd_valid(o_rd_valid),
        .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data), .o_addr(o_addr), .o_cycle_def(def_q),
        .o_addr_oe(o_addr_oe), .o_addr_strobe_n(o_addr_strobe_n), .o_addr_strobe_oe(o_addr_strobe_oe),
        .o_final_transfer_n(o_final_transfer_n), .o_final_transfer_oe(o_final_transfer_oe),
        .o_data(wd_q), .o_data_oe(doe), .i_data(mdata), .i_ready_n(rdy_n), .i_burst_xfer_ready_n(burst_xfer_ready_n_n),
        .i_hold_req(i_hold_req), .o_hold_ack(o_hold_ack));
    cbc_mem_model mem_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_strobe_n(o_addr_strobe_n),
        .i_final_n(o_final_transfer_n), .i_addr(o_addr), .i_mode(mode), .i_waits(waits),
        .i_abort_at(abort_at), .i_idle_low(idle_low), .o_ready_n(rdy_n), .o_burst_ready_n(burst_xfer_ready_n_n),
        .o_data(mdata));

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // Waits for the cycle end so the model mode never changes mid-cycle
    task automatic req(input logic wr, input logic [2:0] len, input logic [1:0] md, input logic [1:0] k);
        int n;
        int w;
        logic [31:0] a;
        n = (len == 3'h0) ? 1 : (len > 3'h4) ? 4 : int'(len);
        if (wr) n = 1;
        if (md == 2'h2 && int'(k) >= n) k = 2'(n - 1);
        w = (md == 2'h0) ? n : (md == 2'h1) ? 1 : int'(k) + 1;
        a = xs();
        mode = md;
        abort_at = k;
        waits = 2'(xs() % 3);
        idle_low = 1'(xs());
        {i_req_valid, i_req_addr, i_req_def, i_req_write, i_req_len, i_req_wdata} = {1'b1, a, 4'(xs()), wr, len, xs()};
        t = 0;
        do begin
            @(posedge i_clock);
            t++;
        end while (!o_req_ready && t < 300);
        if (t >= 300) begin
            check("req_taken", 32'h0, 32'h1);
            results();
        end
        exp_addr = a;
        exp_fin = (n != 1);
        {exp_def, exp_wd, exp_wr} = {i_req_def, i_req_wdata, wr};
        if (!wr) for (int j = 0; j < w; j++) exp_rd.push_back(a + 32'(j));
        exp_ab.push_back(w < n && !wr);
        @(negedge i_clock);
        i_req_valid = 1'b0;
        t = 0;
        while (!o_cycle_done && t < 100) begin
            @(posedge i_clock);
            t++;
        end
        if (t >= 100) begin
            check("cycle_done", 32'h0, 32'h1);
            results();
        end
        @(negedge i_clock);
    endtask : req

    // ************************************************
    // Clock, read side stalls and result monitor
    // ************************************************
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(negedge i_clock) i_rd_ready <= ~stall & ((xs() % 4) != 0);
    always @(posedge i_clock) begin
        if (i_reset_n && o_rd_valid && i_rd_ready) begin
            if (exp_rd.size() == 0) check("rd_extra", 32'h1, 32'h0);
            else check("rd_data", o_rd_data, exp_rd.pop_front());
        end
        if (i_reset_n && o_cycle_done) begin
            if (exp_ab.size() == 0) check("done_extra", 32'h1, 32'h0);
            else check("aborted", 32'(o_cycle_aborted), 32'(exp_ab.pop_front()));
            check("addr_hold", o_addr, exp_addr);
            check("def_hold", 32'(def_q), 32'(exp_def));
        end
        if (i_reset_n && !o_addr_strobe_n) begin
            check("addr", o_addr, exp_addr);
            check("def", 32'(def_q), 32'(exp_def));
            check("data_oe", 32'(doe), 32'(exp_wr));
            if (exp_wr) check("wdata", wd_q, exp_wd);
            check("final_n", 32'(o_final_transfer_n), 32'(exp_fin));
        end
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        {i_reset_n, i_req_valid, i_req_addr, i_req_def, i_req_write, i_req_len, i_req_wdata} = '0;
        {i_hold_req, stall, mode, abort_at, waits, idle_low} = '0;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        i_reset_n = 1'b1;
        check("strobe_rst", 32'(o_addr_strobe_n), 32'h1);
        check("final_rst", 32'(o_final_transfer_n), 32'h1);
        for (int l = 0; l < 8; l++) req(1'b0, 3'(l), 2'h0, 2'h0);
        for (int m = 0; m < 3; m++) req(1'b1, 3'h1, 2'(m), 2'h0);
        req(1'b0, 3'h1, 2'h1, 2'h0);
        req(1'b0, 3'h3, 2'h1, 2'h0);
        for (int k = 0; k < 3; k++) req(1'b0, 3'h4, 2'h2, 2'(k));
        // Drain first: leftover words would block the fourth burst
        for (t = 0; t < 100 && exp_rd.size() > 0; t++) @(negedge i_clock);
        check("rd_drain", 32'(exp_rd.size()), 32'h0);
        // Four full bursts leave the buffer too full to start a read
        stall = 1'b1;
        @(negedge i_clock);
        repeat (4) req(1'b0, 3'h4, 2'h0, 2'h0);
        i_req_write = 1'b0;
        @(negedge i_clock);
        check("req_ready_full", 32'(o_req_ready), 32'h0);
        stall = 1'b0;
        i_hold_req = 1'b1;
        for (t = 0; t < 30 && o_hold_ack !== 1'b1; t++) @(negedge i_clock);
        check("hold_ack", 32'(o_hold_ack), 32'h1);
        check("strobe_oe", 32'(o_addr_strobe_oe), 32'h0);
        check("final_oe", 32'(o_final_transfer_oe), 32'h0);
        check("addr_oe", 32'(o_addr_oe), 32'h0);
        i_hold_req = 1'b0;
        for (t = 0; t < 30 && o_hold_ack !== 1'b0; t++) @(negedge i_clock);
        check("final_oe_back", 32'(o_final_transfer_oe), 32'h1);
        repeat (12) req(xs() % 4 == 0, 3'(xs()), 2'(xs() % 3), 2'(xs()));
        for (t = 0; t < 400 && exp_rd.size() > 0; t++) @(posedge i_clock);
        check("rd_left", 32'(exp_rd.size()), 32'h0);
        check("done_left", 32'(exp_ab.size()), 32'h0);
        results();
    end
endmodule : cbc_bus_ctrl_tb
